// *** rtl/alu_pkg.sv ***
// Purpose: shared types and constants for the integer execution datapath
// Assumes: 32-bit data path, 16-bit immediate field
// Notes: opcode encoding is local to this datapath; the decoder maps onto it
`default_nettype none
package alu_pkg;
  // ----------------------------------------------------------------
  // widths, reset values and fixed data words
  // ----------------------------------------------------------------
  localparam int DATA_W = 32; // operand and result width
  localparam int IMM_W = 16; // immediate field width
  localparam logic [31:0] RESULT_RST = 32'h0000_0000; // result after reset
  localparam logic [31:0] DIV_ZERO_Q = 32'hFFFF_FFFF; // quotient on divide by zero
  localparam logic [31:0] INT_MIN = 32'h8000_0000; // most negative value
  localparam logic [31:0] MINUS_ONE = 32'hFFFF_FFFF; // two's complement -1
  localparam logic [31:0] TRUE_WORD = 32'h0000_0001; // comparison true
  localparam logic [31:0] FALSE_WORD = 32'h0000_0000; // comparison false

  // ----------------------------------------------------------------
  // operation codes
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    op_and = 6'h00, op_or = 6'h01, op_xor = 6'h02, op_nor = 6'h03,
    op_and_imm = 6'h04, op_or_imm = 6'h05, op_xor_imm = 6'h06,
    op_and_hi = 6'h07, op_or_hi = 6'h08, op_xor_hi = 6'h09,
    op_add = 6'h0A, op_sub = 6'h0B, op_mul = 6'h0C, op_div = 6'h0D, op_divu = 6'h0E,
    op_add_imm = 6'h0F, op_sub_imm = 6'h10, op_mul_imm = 6'h11,
    op_mulh_ss = 6'h12, op_mulh_uu = 6'h13, op_mulh_su = 6'h14,
    op_copy = 6'h15, op_mov_simm = 6'h16, op_mov_uimm = 6'h17, op_mov_himm = 6'h18,
    op_eq = 6'h19, op_ne = 6'h1A, op_ge = 6'h1B, op_geu = 6'h1C, op_gt = 6'h1D,
    op_gtu = 6'h1E, op_le = 6'h1F, op_leu = 6'h20, op_lt = 6'h21, op_ltu = 6'h22,
    op_eq_imm = 6'h23, op_ne_imm = 6'h24, op_ge_imm = 6'h25, op_geu_imm = 6'h26,
    op_gt_imm = 6'h27, op_gtu_imm = 6'h28, op_le_imm = 6'h29, op_leu_imm = 6'h2A,
    op_lt_imm = 6'h2B, op_ltu_imm = 6'h2C
  } alu_op_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid; // issue strobe
    alu_op_e op; // operation
    logic [31:0] src_a; // first register operand
    logic [31:0] src_b; // second register operand
    logic [15:0] imm; // immediate field of the instruction word
  } alu_req_s;

  typedef struct packed {
    logic valid; // result strobe
    logic illegal; // unknown op code seen
    logic [31:0] data; // value for the destination register
  } alu_rsp_s;
endpackage
`default_nettype wire

// *** rtl/integer_alu_ops.sv ***
// Purpose: integer execution datapath: logic, arithmetic, moves, compares
// Assumes: operands arrive with a one-cycle issue strobe, result one cycle later
// Notes: divide is single-cycle combinational, sized for a slow processor clock
// Functional notes
// (RULE1) AND, OR, XOR, NOR of two registers
// (RULE2) logic immediates zero-extend sixteen bits
// (RULE3) high logic immediates shift left sixteen
// (RULE4) add, sub, low multiply, both divides
// (RULE5) signed divide two's complement, unsigned magnitude
// (RULE6) add/sub/mul immediates are sign-extended
// (RULE7) high product words, signed and unsigned
// (RULE8) high products need no prior multiply
// (RULE9) mixed signedness high product supported
// (RULE10) copy moves source register unchanged
// (RULE11) signed immediate move sign-extends
// (RULE12) low/high immediate moves zero other half
// (RULE13) full addresses built by two moves; code uses a high move then an OR immediate
// (RULE14) compares write exactly one or zero
// (RULE15) eq, ne, and signed/unsigned relations
// (RULE16) signed less-or-equal uses two's complement
// (RULE17) every compare has an immediate form
// (RULE18) immediate compares extend by signedness
`default_nettype none
module integer_alu_ops (
  input wire logic ref_clk, // processor clock
  input wire logic rst, // asynchronous reset, active high
  input wire alu_pkg::alu_req_s req_i, // issued operation and operands
  output var alu_pkg::alu_rsp_s rsp_o // registered result
);
  import alu_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // sign-extend the immediate field
  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  // zero-extend the immediate field
  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction

  // immediate in the upper half, zeros below
  function automatic logic [31:0] hi16(input logic [15:0] v);
    hi16 = {v, 16'h0000};
  endfunction

  // relational compare; sel: 0 ge, 1 gt, 2 le, 3 lt
  function automatic logic rel(input logic [1:0] sel, input logic sgn, input logic [31:0] x,
                               input logic [31:0] y);
    logic lt;
    logic eq;
    lt = 1'b0;
    eq = (x == y);
    if (sgn) begin
      lt = ($signed(x) < $signed(y));
    end else begin
      lt = (x < y);
    end
    unique case (sel)
      2'h0: rel = !lt; // greater or equal
      2'h1: rel = !lt && !eq; // greater
      2'h2: rel = lt || eq; // less or equal
      default: rel = lt; // less
    endcase
  endfunction

  // boolean to a full result word
  function automatic logic [31:0] flag_word(input logic f);
    flag_word = f ? TRUE_WORD : FALSE_WORD;
  endfunction

  // ----------------------------------------------------------------
  // arithmetic units
  // ----------------------------------------------------------------
  logic [31:0] a; // first operand
  logic [31:0] b; // second register operand
  logic [31:0] si; // sign-extended immediate
  logic [31:0] zi; // zero-extended immediate
  logic [63:0] prod_ss; // signed x signed product
  logic [63:0] prod_uu; // unsigned x unsigned product
  logic [63:0] prod_su; // signed x unsigned product
  logic [31:0] mul_imm; // low word times sign-extended immediate
  logic [31:0] quo_s; // signed quotient
  logic [31:0] quo_u; // unsigned quotient

  assign a = req_i.src_a;
  assign b = req_i.src_b;
  assign si = sext16(req_i.imm); // [RULE6] [RULE18]
  assign zi = zext16(req_i.imm); // [RULE2] [RULE18]

  // each product is formed here from the operands alone [RULE8]
  assign prod_ss = 64'($signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b})); // [RULE7]
  assign prod_uu = 64'({32'h0000_0000, a} * {32'h0000_0000, b}); // [RULE7]
  assign prod_su = 64'($signed({{32{a[31]}}, a}) * $signed({32'h0000_0000, b})); // [RULE9]
  assign mul_imm = 32'(a * si); // [RULE6]

  // divider: zero divisor gives all ones, overflow case gives the minimum [RULE5]
  always_comb begin
    quo_u = DIV_ZERO_Q;
    quo_s = DIV_ZERO_Q;
    if (b != 32'h0000_0000) begin
      quo_u = a / b;
      if (a == INT_MIN && b == MINUS_ONE) begin
        quo_s = INT_MIN; // quotient does not fit, wrap
      end else begin
        quo_s = 32'($signed(a) / $signed(b));
      end
    end
  end

  // ----------------------------------------------------------------
  // result select
  // ----------------------------------------------------------------
  logic [31:0] res_d; // next result word
  logic bad_d; // op code outside the table

  always_comb begin
    res_d = RESULT_RST;
    bad_d = 1'b0;
    unique case (req_i.op)
      op_and: res_d = a & b; // [RULE1]
      op_or: res_d = a | b; // [RULE1]
      op_xor: res_d = a ^ b; // [RULE1]
      op_nor: res_d = ~(a | b); // [RULE1]
      op_and_imm: res_d = a & zi; // [RULE2]
      op_or_imm: res_d = a | zi; // [RULE2]
      op_xor_imm: res_d = a ^ zi; // [RULE2]
      op_and_hi: res_d = a & hi16(req_i.imm); // [RULE3]
      op_or_hi: res_d = a | hi16(req_i.imm); // [RULE3]
      op_xor_hi: res_d = a ^ hi16(req_i.imm); // [RULE3]
      op_add: res_d = a + b; // [RULE4]
      op_sub: res_d = a - b; // [RULE4]
      op_mul: res_d = prod_uu[31:0]; // low word is sign-agnostic [RULE4]
      op_div: res_d = quo_s; // [RULE4] [RULE5]
      op_divu: res_d = quo_u; // [RULE4] [RULE5]
      op_add_imm: res_d = a + si; // [RULE6]
      op_sub_imm: res_d = a - si; // [RULE6]
      op_mul_imm: res_d = mul_imm; // [RULE6]
      op_mulh_ss: res_d = prod_ss[63:32]; // [RULE7]
      op_mulh_uu: res_d = prod_uu[63:32]; // [RULE7]
      op_mulh_su: res_d = prod_su[63:32]; // [RULE9]
      op_copy: res_d = a; // [RULE10]
      op_mov_simm: res_d = si; // [RULE11]
      op_mov_uimm: res_d = zi; // [RULE12]
      op_mov_himm: res_d = hi16(req_i.imm); // [RULE12]
      op_eq: res_d = flag_word(a == b); // [RULE14] [RULE15]
      op_ne: res_d = flag_word(a != b); // [RULE15]
      op_ge: res_d = flag_word(rel(2'h0, 1'b1, a, b)); // [RULE15]
      op_geu: res_d = flag_word(rel(2'h0, 1'b0, a, b)); // [RULE15]
      op_gt: res_d = flag_word(rel(2'h1, 1'b1, a, b)); // [RULE15]
      op_gtu: res_d = flag_word(rel(2'h1, 1'b0, a, b)); // [RULE15]
      op_le: res_d = flag_word(rel(2'h2, 1'b1, a, b)); // signed ordering [RULE16]
      op_leu: res_d = flag_word(rel(2'h2, 1'b0, a, b)); // [RULE15]
      op_lt: res_d = flag_word(rel(2'h3, 1'b1, a, b)); // [RULE15]
      op_ltu: res_d = flag_word(rel(2'h3, 1'b0, a, b)); // [RULE15]
      op_eq_imm: res_d = flag_word(a == si); // [RULE17]
      op_ne_imm: res_d = flag_word(a != si); // [RULE17]
      op_ge_imm: res_d = flag_word(rel(2'h0, 1'b1, a, si)); // [RULE17] [RULE18]
      op_geu_imm: res_d = flag_word(rel(2'h0, 1'b0, a, zi)); // [RULE18]
      op_gt_imm: res_d = flag_word(rel(2'h1, 1'b1, a, si)); // [RULE18]
      op_gtu_imm: res_d = flag_word(rel(2'h1, 1'b0, a, zi)); // [RULE18]
      op_le_imm: res_d = flag_word(rel(2'h2, 1'b1, a, si)); // [RULE16] [RULE18]
      op_leu_imm: res_d = flag_word(rel(2'h2, 1'b0, a, zi)); // [RULE18]
      op_lt_imm: res_d = flag_word(rel(2'h3, 1'b1, a, si)); // [RULE18]
      op_ltu_imm: res_d = flag_word(rel(2'h3, 1'b0, a, zi)); // [RULE18]
      default: bad_d = 1'b1; // unused code, result zero
    endcase
  end

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  logic [31:0] data_q; // destination value, held between issues
  logic bad_q; // last issued op code was unknown
  logic valid_q; // result strobe

  // result word, held until the next issue
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_q <= RESULT_RST;
      bad_q <= 1'b0;
    end else if (req_i.valid) begin
      data_q <= res_d;
      bad_q <= bad_d;
    end
  end

  // result strobe, one cycle after issue
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= req_i.valid;
    end
  end

  // one driver for the whole carrier, so no field has two writers
  assign rsp_o = {valid_q, bad_q, data_q};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // reference product for the high-word check
  logic [63:0] prod_uu_q; // unsigned product of the last cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prod_uu_q <= 64'h0000_0000_0000_0000;
    end else begin
      prod_uu_q <= 64'(65'(req_i.src_a) * 65'(req_i.src_b));
    end
  end

  sequence s_issue(alu_op_e o);
    req_i.valid && req_i.op == o;
  endsequence

  chk_nor_result: assert property (@(posedge ref_clk) disable iff (rst) // [RULE1]
    s_issue(op_nor) |=> rsp_o.data == ~($past(req_i.src_a) | $past(req_i.src_b)))
    else $error("nor result wrong");

  chk_andi_zero_ext: assert property (@(posedge ref_clk) disable iff (rst) // [RULE2]
    s_issue(op_and_imm) |=> rsp_o.data[31:16] == 16'h0000 &&
      rsp_o.data[15:0] == ($past(req_i.src_a[15:0]) & $past(req_i.imm)))
    else $error("and immediate not zero-extended");

  chk_orhi_shift: assert property (@(posedge ref_clk) disable iff (rst) // [RULE3]
    s_issue(op_or_hi) |=> rsp_o.data == ($past(req_i.src_a) | {$past(req_i.imm), 16'h0000}))
    else $error("or high immediate wrong");

  chk_sub_result: assert property (@(posedge ref_clk) disable iff (rst) // [RULE4]
    s_issue(op_sub) |=> rsp_o.data == 32'($past(req_i.src_a) - $past(req_i.src_b)))
    else $error("subtract result wrong");

  chk_divu_quot: assert property (@(posedge ref_clk) disable iff (rst) // [RULE5]
    s_issue(op_divu) ##0 req_i.src_b != 32'h0000_0000 |=>
      rsp_o.data == $past(req_i.src_a) / $past(req_i.src_b))
    else $error("unsigned quotient wrong");

  chk_addi_sext: assert property (@(posedge ref_clk) disable iff (rst) // [RULE6]
    s_issue(op_add_imm) |=>
      rsp_o.data == 32'($past(req_i.src_a) + {{16{$past(req_i.imm[15])}}, $past(req_i.imm)}))
    else $error("add immediate not sign-extended");

  chk_mulh_uu: assert property (@(posedge ref_clk) disable iff (rst) // [RULE7]
    s_issue(op_mulh_uu) |=> rsp_o.data == prod_uu_q[63:32])
    else $error("unsigned high product wrong");

  chk_copy_value: assert property (@(posedge ref_clk) disable iff (rst) // [RULE10]
    s_issue(op_copy) |=> rsp_o.valid && rsp_o.data == $past(req_i.src_a))
    else $error("copy altered value");

  chk_movhi_low: assert property (@(posedge ref_clk) disable iff (rst) // [RULE12]
    s_issue(op_mov_himm) |=> rsp_o.data == {$past(req_i.imm), 16'h0000})
    else $error("high move left low half nonzero");

  chk_cmp_bool: assert property (@(posedge ref_clk) disable iff (rst) // [RULE14]
    req_i.valid && req_i.op >= op_eq && req_i.op <= op_ltu_imm |=> rsp_o.data[31:1] == 31'h0)
    else $error("compare wrote more than one bit");

  chk_le_signed: assert property (@(posedge ref_clk) disable iff (rst) // [RULE16]
    s_issue(op_le) |=> rsp_o.data[0] == ($signed($past(req_i.src_a)) <= $signed($past(req_i.src_b))))
    else $error("signed less-or-equal wrong");

  chk_result_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !req_i.valid |=> $stable(rsp_o.data) && !rsp_o.valid)
    else $error("result changed without issue");

endmodule
`default_nettype wire

// *** tb/alu_src_model.sv ***
// Purpose: register file and decoder stand-in that feeds the datapath
// Assumes: the bench changes the fields at the falling edge
// Notes: idle cycles show inverted operands and immediate with the op code unchanged, so stale operands never look valid
`default_nettype none
module alu_src_model (
  input wire logic ref_clk, // processor clock
  input wire logic rst, // async reset, active high
  input wire logic go, // issue in this cycle
  input wire alu_pkg::alu_op_e op, // op code
  input wire logic [31:0] a, // first operand
  input wire logic [31:0] b, // second operand
  input wire logic [15:0] imm, // immediate field
  input wire alu_pkg::alu_rsp_s rsp_i, // datapath result
  output var alu_pkg::alu_req_s req_o, // issued request
  output logic [31:0] dest_q // destination register
);
  timeunit 1ns;
  timeprecision 1ns;
  import alu_pkg::*;
  // ----------------------------------------------------------------
  // issue, with inverted operands and immediate while idle
  // ----------------------------------------------------------------
  always_comb begin
    req_o = go ? {1'b1, op, a, b, imm} : {1'b0, op, ~a, ~b, ~imm};
  end
  // ----------------------------------------------------------------
  // destination write-back on each result strobe
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dest_q <= RESULT_RST;
    end else if (rsp_i.valid) begin
      dest_q <= rsp_i.data;
    end
  end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self-checking random bench for the integer datapath
// Assumes: one-cycle latency, data holds between issues
// Notes: expected values come from exp_f, with corner operands mixed in
`default_nettype none
module testbench import alu_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0; // processor clock
  logic rst = 1'b1; // reset
  logic go = 1'b0; // issue strobe to the model
  alu_op_e op_r = op_and; // op code to the model
  logic [31:0] a_r = 32'h0, b_r = 32'h0; // operands
  logic [15:0] imm_r = 16'h0; // immediate
  alu_req_s req; // request into the datapath
  alu_rsp_s rsp; // datapath result
  logic [31:0] dest; // model destination register
  logic pv = 1'b0, pi = 1'b0; // expected strobe and illegal flag
  logic [31:0] pe = RESULT_RST; // expected data
  int pk = 0; // kind of last result
  int bad_count = 0, checks = 0, cyc_n = 0;
  logic [31:0] corner [5] = '{32'h0, 32'h1, 32'hFFFFFFFF, 32'h80000000, 32'h7FFFFFFF};

  integer_alu_ops integer_alu_ops_inst (.ref_clk(ref_clk), .rst(rst), .req_i(req), .rsp_o(rsp));
  alu_src_model alu_src_model_inst (.ref_clk(ref_clk), .rst(rst), .go(go), .op(op_r), .a(a_r), .b(b_r),
    .imm(imm_r), .rsp_i(rsp), .req_o(req), .dest_q(dest));

  // ----------------------------------------------------------------
  // clock and timeout
  // ----------------------------------------------------------------
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // reference model and checks
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_f(alu_op_e op, logic [31:0] a, logic [31:0] b, logic [15:0] i);
    logic [31:0] s, z, h, c;
    logic [63:0] ps, pu, px;
    int k;
    logic eqv, lt, cnd;
    logic [31:0] q;
    s = {{16{i[15]}}, i};
    z = {16'h0, i};
    h = {i, 16'h0};
    ps = $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
    pu = {32'h0, a} * {32'h0, b};
    px = $signed({{32{a[31]}}, a}) * $signed({32'h0, b});
    // signed quotient kept out of any mixed-sign select, which would make it unsigned
    q = INT_MIN;
    if (b != 32'h0 && !(a == INT_MIN && b == MINUS_ONE)) begin
      q = $signed(a) / $signed(b);
    end
    k = (op >= op_eq_imm) ? op - op_eq_imm : op - op_eq;
    c = (op < op_eq_imm) ? b : (k >= 3 && k % 2 == 1) ? z : s;
    eqv = a == c;
    lt = (k % 2 == 1) ? a < c : $signed(a) < $signed(c);
    cnd = (k < 2) ? ((k == 1) ^ eqv) : (k < 4) ? !lt : (k < 6) ? !(lt || eqv) : (k < 8) ? (lt || eqv) : lt;
    case (op)
      op_and: return a & b;
      op_or: return a | b;
      op_xor: return a ^ b;
      op_nor: return ~(a | b);
      op_and_imm: return a & z;
      op_or_imm: return a | z;
      op_xor_imm: return a ^ z;
      op_and_hi: return a & h;
      op_or_hi: return a | h;
      op_xor_hi: return a ^ h;
      op_add: return a + b;
      op_sub: return a - b;
      op_mul: return a * b;
      op_div: return (b == 32'h0) ? DIV_ZERO_Q : q;
      op_divu: return (b == 32'h0) ? DIV_ZERO_Q : a / b;
      op_add_imm: return a + s;
      op_sub_imm: return a - s;
      op_mul_imm: return a * s;
      op_mulh_ss: return ps[63:32];
      op_mulh_uu: return pu[63:32];
      op_mulh_su: return px[63:32];
      op_copy: return a;
      op_mov_simm: return s;
      op_mov_uimm: return z;
      op_mov_himm: return h;
      default: return {31'h0, cnd};
    endcase
  endfunction
  task automatic cmp_word(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(string nm, logic e, logic g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  // one cycle: check the previous issue, then drive the next
  task automatic cyc(logic v, alu_op_e op, logic [31:0] a, logic [31:0] b, logic [15:0] i);
    @(negedge ref_clk);
    cmp_bit("valid", pv, rsp.valid);
    cmp_bit("illegal", pi, rsp.illegal);
    if (pk == 2) begin
      cmp_word("flag", pe, rsp.data);
    end else if (pk == 1) begin
      cmp_word("move", pe, rsp.data);
    end else begin
      cmp_word("data", pe, rsp.data);
    end
    go = v;
    op_r = op;
    a_r = a;
    b_r = b;
    imm_r = i;
    pv = v;
    if (v) begin
      pi = op > op_ltu_imm;
      pe = pi ? 32'h0 : exp_f(op, a, b, i);
      pk = (op >= op_eq) ? 2 : (op >= op_copy) ? 1 : 0;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [31:0] pick();
    return ($urandom % 3 == 0) ? corner[$urandom % 5] : $urandom;
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(21261));
    repeat (5) @(negedge ref_clk);
    cmp_word("reset data", RESULT_RST, rsp.data);
    rst = 1'b0;
    $display("test reset done");
    cyc(1'b1, op_mulh_ss, 32'hFFFFFFFE, 32'h00000003, 16'h0);
    cyc(1'b1, op_mulh_uu, 32'hFFFFFFFF, 32'hFFFFFFFF, 16'h0);
    for (int n = 0; n < 3000; n++) begin
      cyc($urandom % 8 != 0, alu_op_e'(6'(n % 45)), pick(), pick(), 16'(($urandom % 2) ? 16'h8000 : $urandom));
    end
    $display("test sweep done");
    cyc(1'b1, alu_op_e'(6'h3F), 32'h5, 32'h6, 16'h7);
    cyc(1'b0, op_and, 32'h0, 32'h0, 16'h0);
    $display("test illegal done");
    cyc(1'b1, op_mov_himm, 32'h0, 32'h0, 16'h1234);
    cyc(1'b0, op_and, 32'h0, 32'h0, 16'h0);
    // dest takes the result one edge after the strobe, so wait once more before reading it
    cyc(1'b0, op_and, 32'h0, 32'h0, 16'h0);
    cyc(1'b1, op_or_imm, dest, 32'h0, 16'h5678);
    cyc(1'b0, op_and, 32'h0, 32'h0, 16'h0);
    cyc(1'b0, op_and, 32'h0, 32'h0, 16'h0);
    cmp_word("dest", 32'h12345678, dest);
    $display("test address load done");
    rst = 1'b1;
    pv = 1'b0;
    pi = 1'b0;
    pe = RESULT_RST;
    @(negedge ref_clk);
    rst = 1'b0;
    cyc(1'b1, op_lt, 32'hFFFFFFFF, 32'h1, 16'h0);
    cyc(1'b1, op_ltu, 32'hFFFFFFFF, 32'h1, 16'h0);
    cyc(1'b0, op_and, 32'h0, 32'h0, 16'h0);
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
